//--- common/ctu_pkg.sv
// constants of the counter/timer unit: register map, control fields,
// counter modes, end actions, interrupt bit positions and fifo geometry.
// assumes a single 32-bit word per register on an ahb-lite slave.
package ctu_pkg;

   // register byte offsets (low 16 address bits decoded)
   localparam logic [15:0] ADDR_CONTROL       = 16'h2000;
   localparam logic [15:0] ADDR_IN_FILL       = 16'h1800;
   localparam logic [15:0] ADDR_IN_DATA       = 16'h1808;
   localparam logic [15:0] ADDR_OUT_FILL      = 16'h1810;
   localparam logic [15:0] ADDR_OUT_DATA      = 16'h1818;
   localparam logic [15:0] ADDR_PRESCALE      = 16'h2008;
   localparam logic [15:0] ADDR_RELOAD_COUNT  = 16'h200C; // wr reload, rd count
   localparam logic [15:0] ADDR_IN_DEBOUNCE   = 16'h2010;
   localparam logic [15:0] ADDR_GATE_DEBOUNCE = 16'h2014;
   localparam logic [15:0] ADDR_PERIODS       = 16'h2018;
   localparam logic [15:0] ADDR_CMP0_HIGH     = 16'h201C; // wr compare 0, rd high
   localparam logic [15:0] ADDR_CMP1_LOW      = 16'h2020; // wr compare 1, rd low
   localparam logic [15:0] ADDR_TIME_BASE     = 16'h2024;
   localparam logic [15:0] ADDR_IRQ_EN_PEND   = 16'h2040; // wr enable, rd pending
   localparam logic [15:0] ADDR_IRQ_CLEAR     = 16'h2044;

   // control register fields
   localparam int CTL_EN_BIT   = 0;
   localparam int CTL_GATE_BIT = 1;
   localparam int CTL_MODE_LSB = 4;
   localparam int CTL_END_LSB  = 8;
   localparam int CTL_SEL_BIT  = 10;

   // counter mode field codes
   localparam logic [3:0] MODE_PLAIN     = 4'h0;
   localparam logic [3:0] MODE_EXT       = 4'h8;
   localparam logic [3:0] MODE_HALF      = 4'h9;
   localparam logic [3:0] MODE_NPER      = 4'hA;
   localparam logic [3:0] MODE_QUAD      = 4'hB;
   localparam logic [3:0] MODE_TRIG_MASK = 4'h4;

   // end actions on compare hit; END_TIMEBASE acts on time base expiry
   localparam logic [1:0] END_CONTINUE = 2'h0;
   localparam logic [1:0] END_RESTART  = 2'h1;
   localparam logic [1:0] END_STOP     = 2'h2;
   localparam logic [1:0] END_TIMEBASE = 2'h3;

   // interrupt bit positions
   localparam int IRQ_DONE = 31;
   localparam int IRQ_LT0  = 30;
   localparam int IRQ_GE0  = 29;
   localparam int IRQ_GE1  = 28;
   localparam int IRQ_IRISE = 27;
   localparam int IRQ_GRISE = 26;
   localparam int IRQ_IFALL = 25;
   localparam int IRQ_GFALL = 24;
   localparam int IRQ_HRDY = 23;
   localparam int IRQ_LRDY = 22;
   localparam int IRQ_IN_LSB  = 19; // empty, half, full at 21..19
   localparam int IRQ_OUT_LSB = 16; // empty, half, full at 18..16
   localparam logic [31:0] IRQ_USED_MASK = 32'hFFFF0000;

   // pin indices into the debounce arrays
   localparam int PIN_IN   = 0;
   localparam int PIN_GATE = 1;

   // fifo geometry
   localparam int FIFO_AW = 8;
   localparam int FIFO_DEPTH = 2 ** FIFO_AW;
   localparam int FILL_W = FIFO_AW + 1;
   localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(FIFO_DEPTH);
   localparam logic [FILL_W-1:0] FILL_HALF = FILL_W'(FIFO_DEPTH / 2);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } ctu_run_t;

endpackage : ctu_pkg

//--- core/ctu_core.sv
// counter/timer unit: prescaler, main counter, compare output, pin
// debounce, period capture, two fifos and interrupt latch, on ahb-lite.
// assumes hclk is the base clock and the pins are asynchronous to it.
`timescale 1ns/1ns
module ctu_core
   import ctu_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        input_clock_pin,
   input  wire logic        gate_pin,
   output logic             count_out,
   output logic             irq
);

   typedef struct packed {
      ctu_run_t                     run;
      logic [31:0]                  control;
      logic [31:0]                  ps_load;
      logic [31:0]                  ps_count;
      logic [31:0]                  reload_value;
      logic [31:0]                  main_count;
      logic [1:0][31:0]             db_limit;
      logic [1:0][31:0]             db_cnt;
      logic [1:0]                   sync_a;
      logic [1:0]                   sync_b;
      logic [1:0]                   filt;
      logic [1:0]                   filt_prev;
      logic [31:0]                  period_average_count;
      logic [31:0]                  period_seen;
      logic                         measuring;
      logic [31:0]                  high_acc;
      logic [31:0]                  low_acc;
      logic [31:0]                  high_phase_capture;
      logic [31:0]                  low_phase_capture;
      logic [31:0]                  compare_zero;
      logic [31:0]                  compare_one;
      logic [31:0]                  time_base_divider;
      logic [31:0]                  tb_count;
      logic [31:0]                  interrupt_enable;
      logic [31:0]                  interrupt_pending;
      logic [FIFO_DEPTH-1:0][31:0]  in_mem;
      logic [FIFO_DEPTH-1:0][31:0]  out_mem;
      logic [FIFO_AW-1:0]           in_wp;
      logic [FIFO_AW-1:0]           in_rp;
      logic [FIFO_AW-1:0]           out_wp;
      logic [FIFO_AW-1:0]           out_rp;
      logic [FILL_W-1:0]            in_fill;
      logic [FILL_W-1:0]            out_fill;
      logic                         wr_pend;
      logic [15:0]                  wr_addr;
      logic [31:0]                  hrdata;
      logic                         hreadyout;
      logic                         hresp;
      logic                         count_out;
      logic                         irq;
   } ctu_state_t;

   ctu_state_t  s;
   ctu_state_t  next_s;

   logic [3:0]  mode;
   logic        is_meas;
   logic        running;
   logic        src_evt;
   logic        gate_ok;
   logic        main_tick;
   logic        cmp_hit;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic        done_evt;
   logic        hrdy_evt;
   logic        lrdy_evt;
   logic        in_push;
   logic        in_pop;
   logic        out_push;
   logic        out_pop;
   logic        bus_take;
   logic [31:0] clr_mask;
   logic [31:0] cond;
   logic [31:0] target;

   // {empty, at least half, full} of a fifo from its fill count
   function automatic logic [2:0] ctu_level(input logic [FILL_W-1:0] fill);
      ctu_level = {fill == '0, fill >= FILL_HALF, fill == FILL_FULL};
   endfunction : ctu_level

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_s   = s;
      done_evt = 1'b0;
      hrdy_evt = 1'b0;
      lrdy_evt = 1'b0;
      in_pop   = 1'b0;
      out_push = 1'b0;
      clr_mask = '0;

      // pin synchronisers and debounce filters, one per pin
      next_s.sync_a    = {gate_pin, input_clock_pin};
      next_s.sync_b    = s.sync_a;
      next_s.filt_prev = s.filt;
      for (int i = 0; i < 2; i++) begin
         if (s.sync_b[i] == s.filt[i]) begin
            next_s.db_cnt[i] = '0;
         end else if (s.db_cnt[i] >= s.db_limit[i]) begin
            next_s.filt[i]   = s.sync_b[i];
            next_s.db_cnt[i] = '0;
         end else begin
            next_s.db_cnt[i] = s.db_cnt[i] + 32'h1;
         end
      end
      rise = s.filt & ~s.filt_prev;
      fall = ~s.filt & s.filt_prev;

      // triggered codes behave as their untriggered partners
      mode    = s.control[CTL_MODE_LSB +: 4] & ~MODE_TRIG_MASK;
      is_meas = (mode == MODE_HALF) || (mode == MODE_NPER);
      running = (s.run == ST_RUN);
      src_evt = (mode == MODE_PLAIN) ? 1'b1 : rise[PIN_IN];
      gate_ok = !s.control[CTL_GATE_BIT] || s.filt[PIN_GATE];

      // prescaler divides source events by load+1
      main_tick = 1'b0;
      if (running && src_evt && gate_ok) begin
         if (s.ps_load == '0) begin
            main_tick = 1'b1;
         end else if (s.ps_count == '0) begin
            next_s.ps_count = s.ps_load;
            main_tick       = 1'b1;
         end else begin
            next_s.ps_count = s.ps_count - 32'h1;
         end
      end

      cmp_hit = s.control[CTL_SEL_BIT] ? (s.main_count == s.compare_one)
                                       : (s.main_count == s.compare_zero);

      // run control and main counter
      unique case (s.run)
         ST_IDLE: begin
            if (s.control[CTL_EN_BIT]) begin
               next_s.run         = ST_RUN;
               next_s.main_count  = s.reload_value;
               next_s.ps_count    = s.ps_load;
               next_s.tb_count    = s.time_base_divider;
               next_s.measuring   = 1'b0;
               next_s.period_seen = '0;
               next_s.high_acc    = '0;
               next_s.low_acc     = '0;
            end
         end
         ST_RUN: begin
            if (s.tb_count != '0) begin
               next_s.tb_count = s.tb_count - 32'h1;
            end
            if (!s.control[CTL_EN_BIT]) begin
               next_s.run = ST_IDLE;
            end else if (!is_meas && (s.control[CTL_END_LSB +: 2] == END_TIMEBASE)
                         && (s.tb_count == '0)) begin
               next_s.run = ST_IDLE;
               next_s.control[CTL_EN_BIT] = 1'b0;
               done_evt = 1'b1;
            end else if (!is_meas && main_tick) begin
               if (cmp_hit && (s.control[CTL_END_LSB +: 2] == END_RESTART)) begin
                  // a queued word from the input fifo becomes the new reload
                  if (s.in_fill != '0) begin
                     next_s.reload_value = s.in_mem[s.in_rp];
                     next_s.main_count   = s.in_mem[s.in_rp];
                     in_pop = 1'b1;
                  end else begin
                     next_s.main_count = s.reload_value;
                  end
               end else if (cmp_hit && (s.control[CTL_END_LSB +: 2] == END_STOP)) begin
                  next_s.run = ST_IDLE;
                  next_s.control[CTL_EN_BIT] = 1'b0;
                  done_evt = 1'b1;
               end else begin
                  next_s.main_count = s.main_count + 32'h1;
               end
            end
         end
         default: begin
            next_s.run = ST_IDLE;
         end
      endcase

      // period measurement, periods start on debounced rising input
      target = (s.period_average_count == '0) ? 32'h1 : s.period_average_count;
      if (running && is_meas) begin
         if (rise[PIN_IN]) begin
            if (s.measuring) begin
               if (s.period_seen + 32'h1 >= target) begin
                  // publish only once all requested periods are seen
                  next_s.high_phase_capture = s.high_acc;
                  hrdy_evt = 1'b1;
                  if (mode == MODE_NPER) begin
                     next_s.low_phase_capture = s.low_acc;
                     lrdy_evt = 1'b1;
                  end
                  out_push           = 1'b1;
                  done_evt           = 1'b1;
                  next_s.period_seen = '0;
                  next_s.high_acc    = '0;
                  next_s.low_acc     = '0;
               end else begin
                  next_s.period_seen = s.period_seen + 32'h1;
               end
            end
            next_s.measuring = 1'b1;
         end else if (s.measuring) begin
            if (s.filt[PIN_IN]) begin
               next_s.high_acc = s.high_acc + 32'h1;
            end else if (mode == MODE_NPER) begin
               next_s.low_acc = s.low_acc + 32'h1;
            end
         end
      end

      // pwm window output
      next_s.count_out = running && !is_meas && (s.main_count >= s.compare_zero)
                         && (s.main_count <= s.compare_one);

      // ahb-lite address phase: reads are answered from this edge's state
      bus_take       = hsel && hready && htrans[1];
      next_s.wr_pend = bus_take && hwrite;
      next_s.wr_addr = haddr[15:0];
      next_s.hreadyout = 1'b1;
      next_s.hresp   = 1'b0;
      out_pop        = 1'b0;
      if (bus_take && !hwrite) begin
         case (haddr[15:0])
            ADDR_CONTROL:      next_s.hrdata = s.control;
            ADDR_IN_FILL:      next_s.hrdata = {23'h0, s.in_fill};
            ADDR_OUT_FILL:     next_s.hrdata = {23'h0, s.out_fill};
            ADDR_OUT_DATA: begin
               next_s.hrdata = (s.out_fill != '0) ? s.out_mem[s.out_rp] : 32'h0;
               out_pop       = (s.out_fill != '0);
            end
            ADDR_PRESCALE:     next_s.hrdata = s.ps_count;
            ADDR_RELOAD_COUNT: next_s.hrdata = s.main_count;
            ADDR_PERIODS:      next_s.hrdata = s.period_average_count;
            ADDR_CMP0_HIGH:    next_s.hrdata = s.high_phase_capture;
            ADDR_CMP1_LOW:     next_s.hrdata = s.low_phase_capture;
            ADDR_IRQ_EN_PEND:  next_s.hrdata = s.interrupt_pending;
            default:           next_s.hrdata = 32'h0;
         endcase
      end

      // ahb-lite data phase writes; software wins over hardware updates, except that a live source beats an irq clear
      in_push = s.wr_pend && (s.wr_addr == ADDR_IN_DATA) && (s.in_fill != FILL_FULL);
      if (s.wr_pend) begin
         case (s.wr_addr)
            ADDR_CONTROL: next_s.control = hwdata;
            ADDR_PRESCALE: begin
               next_s.ps_load  = hwdata;
               next_s.ps_count = hwdata;
            end
            ADDR_RELOAD_COUNT:  next_s.reload_value         = hwdata;
            ADDR_IN_DEBOUNCE:   next_s.db_limit[PIN_IN]     = hwdata;
            ADDR_GATE_DEBOUNCE: next_s.db_limit[PIN_GATE]   = hwdata;
            ADDR_PERIODS:       next_s.period_average_count = hwdata;
            ADDR_CMP0_HIGH:     next_s.compare_zero         = hwdata;
            ADDR_CMP1_LOW:      next_s.compare_one          = hwdata;
            ADDR_TIME_BASE:     next_s.time_base_divider    = hwdata;
            ADDR_IRQ_EN_PEND:   next_s.interrupt_enable = hwdata & IRQ_USED_MASK;
            ADDR_IRQ_CLEAR:     clr_mask = hwdata;
            default: ;
         endcase
      end

      // input fifo: bus fills, restart drains
      if (in_push) begin
         next_s.in_mem[s.in_wp] = hwdata;
         next_s.in_wp = s.in_wp + FIFO_AW'(1);
      end
      if (in_pop) begin
         next_s.in_rp = s.in_rp + FIFO_AW'(1);
      end
      if (in_push && !in_pop) begin
         next_s.in_fill = s.in_fill + FILL_W'(1);
      end else if (!in_push && in_pop) begin
         next_s.in_fill = s.in_fill - FILL_W'(1);
      end

      // output fifo: captures fill, bus drains; a full fifo drops captures
      out_push = out_push && (s.out_fill != FILL_FULL);
      if (out_push) begin
         next_s.out_mem[s.out_wp] = s.high_acc;
         next_s.out_wp = s.out_wp + FIFO_AW'(1);
      end
      if (out_pop) begin
         next_s.out_rp = s.out_rp + FIFO_AW'(1);
      end
      if (out_push && !out_pop) begin
         next_s.out_fill = s.out_fill + FILL_W'(1);
      end else if (!out_push && out_pop) begin
         next_s.out_fill = s.out_fill - FILL_W'(1);
      end

      // interrupt sources in enable-register order
      cond = '0;
      cond[IRQ_DONE]  = done_evt;
      cond[IRQ_LT0]   = running && !is_meas && (s.main_count < s.compare_zero);
      cond[IRQ_GE0]   = running && !is_meas && (s.main_count >= s.compare_zero);
      cond[IRQ_GE1]   = running && !is_meas && (s.main_count >= s.compare_one);
      cond[IRQ_IRISE] = rise[PIN_IN];
      cond[IRQ_GRISE] = rise[PIN_GATE];
      cond[IRQ_IFALL] = fall[PIN_IN];
      cond[IRQ_GFALL] = fall[PIN_GATE];
      cond[IRQ_HRDY]  = hrdy_evt;
      cond[IRQ_LRDY]  = lrdy_evt;
      cond[IRQ_IN_LSB +: 3]  = ctu_level(s.in_fill);
      cond[IRQ_OUT_LSB +: 3] = ctu_level(s.out_fill);

      // set wins over clear, so a live source refires at once
      next_s.interrupt_pending = ((s.interrupt_pending & ~clr_mask)
                                 | (cond & s.interrupt_enable)) & IRQ_USED_MASK;
      next_s.irq = |next_s.interrupt_pending;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s           <= '0;
         s.run       <= ST_IDLE;
         s.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign hreadyout = s.hreadyout;
   assign hresp     = s.hresp;
   assign hrdata    = s.hrdata;
   assign count_out = s.count_out;
   assign irq       = s.irq;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_irq_tracks_pending: assert property (s.irq == (s.interrupt_pending != '0))
      else $error("irq differs from pending bits");
   a_reserved_stay_zero: assert property (s.interrupt_pending[15:0] == 16'h0)
      else $error("reserved pending bit set");
   a_pending_needs_enable: assert property (
      $rose(s.interrupt_pending[IRQ_IRISE]) |-> $past(s.interrupt_enable[IRQ_IRISE]))
      else $error("pending set without enable");
   a_clear_drops_idle: assert property (
      s.wr_pend && (s.wr_addr == ADDR_IRQ_CLEAR) && hwdata[IRQ_DONE] && !done_evt
      |=> !s.interrupt_pending[IRQ_DONE])
      else $error("cleared bit stayed pending");
   a_pwm_window_high: assert property (
      running && !is_meas && (s.main_count >= s.compare_zero)
      && (s.main_count <= s.compare_one) |=> s.count_out)
      else $error("output low inside compare window");
   a_count_snapshot: assert property (
      bus_take && !hwrite && (haddr[15:0] == ADDR_RELOAD_COUNT)
      |=> s.hrdata == $past(s.main_count))
      else $error("count read not the value at access");
   a_prescale_read: assert property (
      bus_take && !hwrite && (haddr[15:0] == ADDR_PRESCALE)
      |=> s.hrdata == $past(s.ps_count))
      else $error("prescaler read mismatch");
   a_bypass_tick: assert property (
      running && (mode == MODE_PLAIN) && (s.ps_load == '0) && gate_ok && !cmp_hit
      && s.control[CTL_EN_BIT] && (s.control[CTL_END_LSB +: 2] != END_TIMEBASE)
      && !s.wr_pend |=> s.main_count == $past(s.main_count) + 32'h1)
      else $error("zero prescaler did not bypass");
   a_input_debounce: assert property (
      $changed(s.filt[PIN_IN]) |-> $past(s.db_cnt[PIN_IN] >= s.db_limit[PIN_IN]))
      else $error("input qualified too early");
   a_gate_debounce: assert property (
      $changed(s.filt[PIN_GATE]) |-> $past(s.db_cnt[PIN_GATE] >= s.db_limit[PIN_GATE]))
      else $error("gate qualified too early");
   a_start_reload: assert property (
      (s.run == ST_IDLE) ##1 (s.run == ST_RUN) |-> s.main_count == $past(s.reload_value))
      else $error("start did not load reload value");

   c_pwm_pulse:    cover property (!s.count_out ##1 s.count_out);
   c_capture_done: cover property (hrdy_evt && lrdy_evt);
   c_irq_raised:   cover property ($rose(s.irq));
   c_in_fifo_full: cover property (s.in_fill == FILL_FULL);

endmodule : ctu_core

//--- tb/ctu_pins.sv
// far-side model: drives the input clock and gate pins of the unit.
// assumes the bench asks for pin levels in base clock cycles.
`timescale 1ns/1ns
module ctu_pins (
   input  wire logic       hclk,
   input  wire logic [1:0] level,
   output logic            input_clock_pin,
   output logic            gate_pin
);
   // pins follow the request one edge later, never mid-cycle
   always_ff @(posedge hclk) begin
      input_clock_pin <= level[0];
      gate_pin        <= level[1];
   end
endmodule : ctu_pins

//--- tb/counter_timer_unit_test.sv
// self-checking bench for the counter/timer unit over ahb-lite.
// assumes zero-wait slave; pins come from the ctu_pins model.
`timescale 1ns/1ns
module counter_timer_unit_test;
   import ctu_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 0, level = 0;
   logic [31:0] haddr = 0, hwdata = 0, rv;
   wire  logic  hreadyout, hresp, count_out, irq, in_pin, gate_pin;
   wire  logic [31:0] hrdata;
   int          n_errors = 0, samples_checked = 0;
   always #20 hclk = ~hclk;
   ctu_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .input_clock_pin(in_pin), .gate_pin(gate_pin), .count_out(count_out), .irq(irq));
   ctu_pins pins (.hclk(hclk), .level(level), .input_clock_pin(in_pin),
      .gate_pin(gate_pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string name, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // bounded wait for hready; a hang ends the run
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 50) begin
            n_errors++;
            tally_and_finish();
         end
         @(posedge hclk);
      end
   endtask : wait_rdy
   // one single transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {16'h0000, a};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rv = hrdata;
   endtask : bus
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input string n, input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      chk(n, rv, e);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      // level source refires after clear while enabled; reserved bits stay 0
      wr(ADDR_IRQ_EN_PEND, 32'h0020FFFF);
      @(posedge hclk); // pending latches one edge after the enable lands
      rd("pending", ADDR_IRQ_EN_PEND, 32'h00200000);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_CLEAR, 32'h00200000);
      rd("refire", ADDR_IRQ_EN_PEND, 32'h00200000);
      wr(ADDR_IRQ_EN_PEND, 32'h00000000);
      wr(ADDR_IRQ_CLEAR, 32'hFFFFFFFF);
      rd("cleared", ADDR_IRQ_EN_PEND, 32'h00000000);
      chk("irq low", {31'h0, irq}, 32'h0);
      $display("test irq done");
      // three pushes show in the fill count; empty pops give 0
      for (int i = 0; i < 3; i++) wr(ADDR_IN_DATA, 32'hA5A50000 + i);
      rd("in fill", ADDR_IN_FILL, 32'h00000003);
      rd("out fill", ADDR_OUT_FILL, 32'h00000000);
      rd("out pop", ADDR_OUT_DATA, 32'h00000000);
      rd("unmapped", 16'h2100, 32'h00000000);
      $display("test fifo done");
      // plain mode from reload 5 stops at compare one 10
      wr(ADDR_PRESCALE, 32'h00000007);
      rd("prescale", ADDR_PRESCALE, 32'h00000007);
      wr(ADDR_PRESCALE, 32'h00000000);
      wr(ADDR_RELOAD_COUNT, 32'h00000005);
      wr(ADDR_CMP0_HIGH, 32'h00000008);
      wr(ADDR_CMP1_LOW, 32'h0000000A);
      wr(ADDR_CONTROL, 32'h00000601);
      repeat (30) @(posedge hclk);
      rd("count", ADDR_RELOAD_COUNT, 32'h0000000A);
      chk("out idle", {31'h0, count_out}, 32'h0);
      $display("test count done");
      // a glitch as long as the debounce limit raises no edge event
      wr(ADDR_IN_DEBOUNCE, 32'h00000003);
      wr(ADDR_IRQ_EN_PEND, 32'h08000000);
      wr(ADDR_IRQ_CLEAR, 32'hFFFFFFFF);
      level <= 2'b01;
      repeat (3) @(posedge hclk);
      level <= 2'b00;
      repeat (15) @(posedge hclk);
      rd("glitch", ADDR_IRQ_EN_PEND, 32'h00000000);
      level <= 2'b01;
      repeat (15) @(posedge hclk);
      rd("rise", ADDR_IRQ_EN_PEND, 32'h08000000);
      $display("test debounce done");
      tally_and_finish();
   end
endmodule : counter_timer_unit_test
